// File: pkg/ctdb_pkg.sv
package ctdb_pkg;

   // ******************************************************
   // Bus and register map
   // ******************************************************
   localparam int         CTDB_AW     = 5;
   localparam int         CTDB_DW     = 32;
   localparam int         CTDB_BYTE_W = 8;
   localparam int         CTDB_CNT_W  = 16;
   localparam int         CTDB_CTRL_W = 3;
   localparam logic [4:0] CTDB_OFS_LMODE = 5'h00;
   localparam logic [4:0] CTDB_OFS_HMODE = 5'h04;
   localparam logic [4:0] CTDB_OFS_CTRL  = 5'h08;
   localparam logic [4:0] CTDB_OFS_LPER  = 5'h0c;
   localparam logic [4:0] CTDB_OFS_HPER  = 5'h10;
   localparam logic [4:0] CTDB_OFS_LDUTY = 5'h14;
   localparam logic [4:0] CTDB_OFS_STAT  = 5'h18;

   // ******************************************************
   // Reset values and constants
   // ******************************************************
   localparam logic [7:0]  CTDB_MODE_RST  = 8'h00;
   localparam logic [2:0]  CTDB_CTRL_RST  = 3'h0;
   localparam logic [7:0]  CTDB_CMP8_RST  = 8'hff;
   localparam logic [15:0] CTDB_CMP16_RST = 16'hffff;
   localparam logic [7:0]  CTDB_CNT8_ZERO = 8'h00;
   localparam logic [15:0] CTDB_CNT16_ZERO = 16'h0000;
   localparam logic [7:0]  CTDB_CNT8_ONE  = 8'h01;
   localparam logic [15:0] CTDB_CNT16_ONE = 16'h0001;
   localparam logic [23:0] CTDB_PAD24     = 24'h000000;
   localparam logic [28:0] CTDB_PAD29     = 29'h00000000;
   localparam logic [31:0] CTDB_WORD_ZERO = 32'h00000000;

   // ******************************************************
   // Mode encodings
   // ******************************************************
   localparam logic [1:0] CTDB_TCM_T16A = 2'h0;
   localparam logic [1:0] CTDB_TCM_T16B = 2'h1;
   localparam logic [1:0] CTDB_TCM_PPG  = 2'h2;

   // ******************************************************
   // Source clock prescaler
   // ******************************************************
   localparam int          CTDB_PW    = 11;
   localparam int          CTDB_NCH   = 2;
   localparam int          CTDB_CH_LO = 0;
   localparam int          CTDB_CH_HI = 1;
   localparam logic [10:0] CTDB_DIV_MASK [0:7] = '{11'h7ff, 11'h3ff, 11'h0ff,
      11'h03f, 11'h00f, 11'h003, 11'h001, 11'h000};

   typedef struct packed {
      logic       dbe;
      logic       tff;
      logic [1:0] tcm;
      logic       ein;
      logic [2:0] tck;
   } ctdb_mode_t;

   typedef struct packed {
      logic cas;
      logic hrun;
      logic lrun;
   } ctdb_ctrl_t;

endpackage

// File: hw/ctdb_presc.sv
`timescale 1ns/1ps
`default_nettype none
module ctdb_presc (
   input  wire logic                                 pclk,
   input  wire logic                                 presetn,
   input  wire logic                                 ce,
   input  wire logic [ctdb_pkg::CTDB_NCH-1:0][2:0]   sel,
   output var  logic [ctdb_pkg::CTDB_NCH-1:0]        tick
);
   import ctdb_pkg::*;

   logic [CTDB_PW-1:0]  div_ff;
   wire logic [CTDB_NCH-1:0] due;

   function automatic logic [CTDB_PW-1:0] div_mask(input logic [2:0] s);
      div_mask = CTDB_DIV_MASK[s];
   endfunction

   // ******************************************************
   // Free running divider shared by both channels
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
      end else if (ce) begin
         div_ff <= div_ff + 1'b1;
      end
   end

   for (genvar ch = 0; ch < CTDB_NCH; ch++) begin : g_tick
      wire logic [CTDB_PW-1:0] msk = div_mask(sel[ch]);
      assign due[ch] = (div_ff & msk) == msk;
   end

   // One register for all ticks keeps a single driver on the output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= '0;
      end else if (ce) begin
         tick <= due;
      end
   end

endmodule
`default_nettype wire

// File: hw/ctdb_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
module ctdb_timer_pair (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          ce,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ctdb_pkg::CTDB_AW-1:0]  paddr,
   input  wire logic [ctdb_pkg::CTDB_DW-1:0]  pwdata,
   input  wire logic [3:0]                    pstrb,
   output var  logic [ctdb_pkg::CTDB_DW-1:0]  prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   output var  logic                          pulse_output_pin,
   output var  logic                          low_channel_irq,
   output var  logic                          high_channel_irq
);
   import ctdb_pkg::*;

   function automatic logic hit(input logic [CTDB_AW-1:0] a,
                                input logic [CTDB_AW-1:0] ofs);
      hit = a == ofs;
   endfunction

   // ******************************************************
   // Storage
   // ******************************************************
   ctdb_mode_t       lmode_ff;
   ctdb_mode_t       hmode_ff;
   ctdb_ctrl_t       ctrl_ff;
   logic [7:0]       duty_buf_ff;
   logic [7:0]       duty_act_ff;
   logic [7:0]       plo_buf_ff;
   logic [7:0]       plo_act_ff;
   logic [7:0]       phi_buf_ff;
   logic [15:0]      jbuf_ff;
   logic [15:0]      jact_ff;
   logic [7:0]       cnt_lo_ff;
   logic [15:0]      cnt16_ff;
   logic             dseen_ff;
   logic             pseen_ff;
   logic             seen16_ff;
   logic             phase_ff;
   logic [CTDB_NCH-1:0] tick;

   // ******************************************************
   // APB decode
   // ******************************************************
   wire logic       acc    = psel & penable;
   wire logic       fin    = acc & pready;
   wire logic       wr     = fin & pwrite & pstrb[0];
   wire logic [7:0] w8     = pwdata[CTDB_BYTE_W-1:0];
   wire logic       known  = hit(paddr, CTDB_OFS_LMODE) | hit(paddr, CTDB_OFS_HMODE)
                           | hit(paddr, CTDB_OFS_CTRL)  | hit(paddr, CTDB_OFS_LPER)
                           | hit(paddr, CTDB_OFS_HPER)  | hit(paddr, CTDB_OFS_LDUTY)
                           | hit(paddr, CTDB_OFS_STAT);
   wire logic       wr_lmode = wr & hit(paddr, CTDB_OFS_LMODE);
   wire logic       wr_hmode = wr & hit(paddr, CTDB_OFS_HMODE);
   wire logic       wr_ctrl  = wr & hit(paddr, CTDB_OFS_CTRL);
   wire logic       wr_plo   = wr & hit(paddr, CTDB_OFS_LPER);
   wire logic       wr_phi   = wr & hit(paddr, CTDB_OFS_HPER);
   wire logic       wr_duty  = wr & hit(paddr, CTDB_OFS_LDUTY);
   wire logic       rd_start = acc & ~pready & ~pwrite;

   // Shadow values are what software sees on reads
   wire logic [31:0] rd_word =
      hit(paddr, CTDB_OFS_LMODE) ? {CTDB_PAD24, lmode_ff} :
      hit(paddr, CTDB_OFS_HMODE) ? {CTDB_PAD24, hmode_ff} :
      hit(paddr, CTDB_OFS_CTRL)  ? {CTDB_PAD29, ctrl_ff} :
      hit(paddr, CTDB_OFS_LPER)  ? {CTDB_PAD24, plo_buf_ff} :
      hit(paddr, CTDB_OFS_HPER)  ? {CTDB_PAD24, phi_buf_ff} :
      hit(paddr, CTDB_OFS_LDUTY) ? {CTDB_PAD24, duty_buf_ff} :
      hit(paddr, CTDB_OFS_STAT)  ? {cnt16_ff, CTDB_CNT8_ZERO, cnt_lo_ff} :
      CTDB_WORD_ZERO;

   // ******************************************************
   // Mode qualification
   // ******************************************************
   wire logic lrun = ctrl_ff.lrun;
   wire logic hrun = ctrl_ff.hrun;
   wire logic cas  = ctrl_ff.cas;
   wire logic ldbe = lmode_ff.dbe;
   wire logic hdbe = hmode_ff.dbe;
   // Lower channel counts only as a pulse generator outside cascade
   wire logic lo_en = ~cas & lrun & (lmode_ff.tcm == CTDB_TCM_PPG);
   wire logic e16 = cas & hrun & ~hmode_ff.ein
                  & ((hmode_ff.tcm == CTDB_TCM_T16A) | (hmode_ff.tcm == CTDB_TCM_T16B));
   wire logic tick_lo = tick[CTDB_CH_LO];
   wire logic tick_hi = tick[CTDB_CH_HI];

   // Compare is continuous so a direct write equal to the count hits at once
   wire logic m_duty = lo_en & ~dseen_ff & (cnt_lo_ff == duty_act_ff);
   wire logic m_per  = lo_en & ~pseen_ff & (cnt_lo_ff == plo_act_ff);
   wire logic m16    = e16 & ~seen16_ff & (cnt16_ff == jact_ff);

   // ******************************************************
   // Next values
   // ******************************************************
   wire logic lo_direct = ~lrun | ~ldbe;
   wire logic hi_direct = ~hrun | ~hdbe;
   wire logic [15:0] jnew = {w8, plo_buf_ff};

   wire logic [7:0] nxt_duty_act =
      (wr_duty & lo_direct) ? w8 :
      (m_per & ldbe)        ? duty_buf_ff :
      duty_act_ff;
   wire logic [7:0] nxt_plo_act =
      (wr_plo & ~cas & lo_direct) ? w8 :
      (m_per & ldbe)              ? plo_buf_ff :
      plo_act_ff;
   wire logic [15:0] nxt_jact =
      (wr_phi & hi_direct) ? jnew :
      (m16 & hdbe)         ? jbuf_ff :
      jact_ff;

   // Counters wrap naturally through all ones
   wire logic [7:0] nxt_cnt_lo =
      (~lo_en | m_per) ? CTDB_CNT8_ZERO :
      tick_lo          ? cnt_lo_ff + CTDB_CNT8_ONE :
      cnt_lo_ff;
   wire logic [15:0] nxt_cnt16 =
      (~e16 | m16) ? CTDB_CNT16_ZERO :
      tick_hi      ? cnt16_ff + CTDB_CNT16_ONE :
      cnt16_ff;

   // A seen flag stops one count value from matching twice
   wire logic nxt_pseen  = ~lo_en ? 1'b0 : m_per ? 1'b1 : tick_lo ? 1'b0 : pseen_ff;
   wire logic nxt_dseen  = (~lo_en | m_per | tick_lo) ? 1'b0 : m_duty ? 1'b1 : dseen_ff;
   wire logic nxt_seen16 = ~e16 ? 1'b0 : m16 ? 1'b1 : tick_hi ? 1'b0 : seen16_ff;
   wire logic nxt_phase  = (~lo_en | m_per) ? 1'b0 :
                           m_duty ? ~phase_ff : phase_ff;

   // ******************************************************
   // Prescaler
   // ******************************************************
   ctdb_presc u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .sel     ({hmode_ff.tck, lmode_ff.tck}),
      .tick    (tick)
   );

   // ******************************************************
   // APB answer, one wait state
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= CTDB_WORD_ZERO;
      end else if (ce) begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~known;
         if (rd_start) begin
            prdata <= rd_word;
         end
      end
   end

   // ******************************************************
   // Configuration
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lmode_ff <= ctdb_mode_t'(CTDB_MODE_RST);
         hmode_ff <= ctdb_mode_t'(CTDB_MODE_RST);
         ctrl_ff  <= ctdb_ctrl_t'(CTDB_CTRL_RST);
      end else if (ce) begin
         if (wr_lmode & ~lrun) begin
            lmode_ff <= ctdb_mode_t'(w8);
         end
         if (wr_hmode & ~hrun & ~lrun) begin
            hmode_ff <= ctdb_mode_t'(w8);
         end
         if (wr_ctrl) begin
            ctrl_ff <= ctdb_ctrl_t'(pwdata[CTDB_CTRL_W-1:0]);
         end
      end
   end

   // ******************************************************
   // Compare shadows and active values
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_buf_ff <= CTDB_CMP8_RST;
         plo_buf_ff  <= CTDB_CMP8_RST;
         phi_buf_ff  <= CTDB_CMP8_RST;
         jbuf_ff     <= CTDB_CMP16_RST;
      end else if (ce) begin
         if (wr_duty) begin
            duty_buf_ff <= w8;
         end
         if (wr_plo) begin
            plo_buf_ff <= w8;
         end
         if (wr_phi) begin
            phi_buf_ff <= w8;
            jbuf_ff    <= jnew;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_act_ff <= CTDB_CMP8_RST;
         plo_act_ff  <= CTDB_CMP8_RST;
         jact_ff     <= CTDB_CMP16_RST;
      end else if (ce) begin
         duty_act_ff <= nxt_duty_act;
         plo_act_ff  <= nxt_plo_act;
         jact_ff     <= nxt_jact;
      end
   end

   // ******************************************************
   // Counters and output
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_lo_ff <= CTDB_CNT8_ZERO;
         cnt16_ff  <= CTDB_CNT16_ZERO;
         dseen_ff  <= 1'b0;
         pseen_ff  <= 1'b0;
         seen16_ff <= 1'b0;
         phase_ff  <= 1'b0;
      end else if (ce) begin
         cnt_lo_ff <= nxt_cnt_lo;
         cnt16_ff  <= nxt_cnt16;
         dseen_ff  <= nxt_dseen;
         pseen_ff  <= nxt_pseen;
         seen16_ff <= nxt_seen16;
         phase_ff  <= nxt_phase;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_output_pin <= 1'b0;
         low_channel_irq  <= 1'b0;
         high_channel_irq <= 1'b0;
      end else if (ce) begin
         pulse_output_pin <= lmode_ff.tff ^ nxt_phase;
         low_channel_irq  <= m_per;
         high_channel_irq <= m16;
      end
   end

   // ******************************************************
   // Checks
   // ******************************************************
   a_buf_hold_run: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_duty & lrun & ldbe & ~m_per |=> duty_act_ff == $past(duty_act_ff))
      else $error("buffered write changed active duty");

   a_read_shadow: assert property (@(posedge pclk) disable iff (!presetn)
      ce & rd_start & hit(paddr, CTDB_OFS_LDUTY) & ~wr_duty
      |=> prdata[CTDB_BYTE_W-1:0] == duty_buf_ff)
      else $error("duty read did not return shadow");

   a_stop_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_duty & ~lrun
      |=> duty_act_ff == $past(w8) && duty_buf_ff == $past(w8))
      else $error("stopped write missed active or shadow");

   a_nobuf_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_plo & ~ldbe & ~cas |=> plo_act_ff == $past(w8))
      else $error("unbuffered period write not immediate");

   a_equal_match: assert property (@(posedge pclk) disable iff (!presetn)
      ce & m_duty & ~m_per |=> pulse_output_pin != $past(pulse_output_pin))
      else $error("duty match did not toggle output");

   a_cascade_idle: assert property (@(posedge pclk) disable iff (!presetn)
      ce & cas |=> cnt_lo_ff == CTDB_CNT8_ZERO && !low_channel_irq)
      else $error("lower channel active in cascade");

   a_joint_load: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_phi & hi_direct
      |=> jact_ff == {$past(w8), $past(plo_buf_ff)})
      else $error("joined compare not loaded on high write");

   a_mode_locked: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_hmode & (hrun | lrun) |=> hmode_ff == $past(hmode_ff))
      else $error("high mode changed while running");

   a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ce & m16 |=> high_channel_irq && cnt16_ff == CTDB_CNT16_ZERO)
      else $error("16-bit match without irq and clear");

   a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ce & ~hrun |=> cnt16_ff == CTDB_CNT16_ZERO)
      else $error("16-bit counter not cleared when stopped");

   a_buf16_load: assert property (@(posedge pclk) disable iff (!presetn)
      ce & m16 & hdbe & ~wr_phi |=> jact_ff == $past(jbuf_ff))
      else $error("16-bit shadow not loaded at match");

   a_period_irq: assert property (@(posedge pclk) disable iff (!presetn)
      ce & m_per |=> low_channel_irq && pulse_output_pin == lmode_ff.tff)
      else $error("period match without irq or initial level");

   a_buf_per_load: assert property (@(posedge pclk) disable iff (!presetn)
      ce & m_per & ldbe |=> plo_act_ff == $past(plo_buf_ff))
      else $error("period shadow not loaded at period match");

   a_equal_period: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_plo & ~ldbe & lo_en & ~nxt_pseen & (w8 == nxt_cnt_lo)
      |=> m_per)
      else $error("period write equal to count did not match at once");

   a_equal_joint: assert property (@(posedge pclk) disable iff (!presetn)
      ce & wr_phi & ~hdbe & e16 & ~nxt_seen16 & (jnew == nxt_cnt16)
      |=> m16)
      else $error("joined write equal to count did not match at once");

   a_read_joint: assert property (@(posedge pclk) disable iff (!presetn)
      ce & rd_start & hit(paddr, CTDB_OFS_HPER)
      |=> prdata[CTDB_BYTE_W-1:0] == $past(phi_buf_ff))
      else $error("high period read did not return last write");

endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module testbench;
   import ctdb_pkg::*;
   logic               pclk;
   logic               presetn;
   logic               ce;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [CTDB_AW-1:0] paddr;
   logic [CTDB_DW-1:0] pwdata;
   logic [CTDB_DW-1:0] prdata;
   logic [CTDB_DW-1:0] rd;
   logic [3:0]         pstrb;
   logic               pready;
   logic               pslverr;
   logic               pulse_output_pin;
   logic               low_channel_irq;
   logic               high_channel_irq;
   logic               err;
   logic               got;
   int                 errors;
   int                 n_checks;
   int                 cyc;
   int                 gap;
   int                 act;
   int                 t0;
   logic [7:0]         per;
   logic [7:0]         duty;
   logic [7:0]         m;

   ctdb_timer_pair dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_output_pin(pulse_output_pin), .low_channel_irq(low_channel_irq),
      .high_channel_irq(high_channel_irq));

   // ***************************************************
   // Clock, cycle count and timeout
   // ***************************************************
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc > 60000) begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Irq spacing when the counter runs from zero up to the compare value
   function automatic int irq_gap(input int cmp);
      irq_gap = cmp + 1;
   endfunction

   // ***************************************************
   // Bus cycles
   // ***************************************************
   task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      apb(1'b1, a, {CTDB_PAD24, d});
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] ex, input logic ee);
      apb(1'b0, a, CTDB_WORD_ZERO);
      `CHK("read data", ex, rd)
      `CHK("slave error", ee, err)
   endtask

   // ***************************************************
   // Timer observation
   // ***************************************************
   task automatic wait_irq(input logic hi, input int lim);
      int k;
      got = 1'b0;
      for (k = 0; k < lim && !got; k++) begin
         @(posedge pclk);
         #1;
         got = ((hi ? high_channel_irq : low_channel_irq) === 1'b1);
      end
      t0 = cyc;
   endtask

   task automatic measure(input logic hi, input logic tff);
      int s;
      wait_irq(hi, 3000);
      s = t0;
      act = 0;
      got = 1'b0;
      while (!got && cyc - s < 3000) begin
         @(posedge pclk);
         #1;
         got = ((hi ? high_channel_irq : low_channel_irq) === 1'b1);
         if (!got && pulse_output_pin === ~tff) begin
            act++;
         end
      end
      gap = cyc - s;
   endtask

   task automatic lo_cfg(input logic [7:0] md, input logic [7:0] p, input logic [7:0] d);
      wr(CTDB_OFS_CTRL, 8'h00);
      wr(CTDB_OFS_LMODE, md);
      wr(CTDB_OFS_LPER, p);
      wr(CTDB_OFS_LDUTY, d);
      wr(CTDB_OFS_CTRL, 8'h01);
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      errors = 0;
      n_checks = 0;
      cyc = 0;
      void'($urandom(17));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(CTDB_OFS_LMODE, 32'h00000000, 1'b0);
      rdchk(CTDB_OFS_CTRL, 32'h00000000, 1'b0);
      rdchk(CTDB_OFS_LPER, 32'h000000ff, 1'b0);
      rdchk(CTDB_OFS_HPER, 32'h000000ff, 1'b0);
      rdchk(5'h1c, 32'h00000000, 1'b1);
      for (int i = 0; i < 4; i++) begin
         per = 8'($urandom_range(60, 8));
         duty = 8'($urandom_range(per - 2, 1));
         m = {i[1], i[0], 6'h27};
         lo_cfg(m, per, duty);
         measure(1'b0, i[0]);
         `CHK("pulse period", irq_gap(per), gap)
         `CHK("active width", per - duty, act)
         rdchk(CTDB_OFS_LDUTY, {CTDB_PAD24, duty}, 1'b0);
      end
      lo_cfg(8'ha7, 8'd40, 8'd10);
      wait_irq(1'b0, 3000);
      gap = t0;
      wr(CTDB_OFS_LPER, 8'd20);
      wait_irq(1'b0, 3000);
      `CHK("buffered gap", irq_gap(40), t0 - gap)
      rdchk(CTDB_OFS_LPER, 32'h00000014, 1'b0);
      measure(1'b0, 1'b0);
      `CHK("buffered new gap", irq_gap(20), gap)
      lo_cfg(8'h27, 8'd40, 8'd10);
      wait_irq(1'b0, 3000);
      gap = t0;
      wr(CTDB_OFS_LPER, 8'd20);
      wait_irq(1'b0, 3000);
      `CHK("direct gap", irq_gap(20), t0 - gap)
      gap = t0;
      wr(CTDB_OFS_LPER, 8'd4);
      wait_irq(1'b0, 3000);
      `CHK("equal gap", 5, t0 - gap)
      gap = t0;
      wr(CTDB_OFS_LPER, 8'd2);
      wait_irq(1'b0, 3000);
      `CHK("wrap gap", 259, t0 - gap)
      lo_cfg(8'h07, 8'd10, 8'd5);
      wait_irq(1'b0, 300);
      `CHK("idle mode irq", 1'b0, got)
      for (int i = 0; i < 2; i++) begin
         m = i ? 8'h97 : 8'h07;
         wr(CTDB_OFS_CTRL, 8'h00);
         rdchk(CTDB_OFS_STAT, 32'h00000000, 1'b0);
         wr(CTDB_OFS_LMODE, 8'h27);
         wr(CTDB_OFS_HMODE, m);
         wr(CTDB_OFS_LPER, 8'h23);
         wr(CTDB_OFS_HPER, 8'h01);
         wr(CTDB_OFS_CTRL, 8'h06);
         measure(1'b1, 1'b0);
         `CHK("joined gap", 16'h0124, gap)
         wr(CTDB_OFS_HMODE, 8'h00);
         rdchk(CTDB_OFS_HMODE, {CTDB_PAD24, m}, 1'b0);
         wait_irq(1'b1, 3000);
         gap = t0;
         wr(CTDB_OFS_LPER, 8'h40);
         wr(CTDB_OFS_HPER, 8'h00);
         wait_irq(1'b1, 3000);
         `CHK("joined new gap", i ? 16'h0124 : 16'h0041, t0 - gap)
         measure(1'b1, 1'b0);
         `CHK("joined later gap", 16'h0041, gap)
         rdchk(CTDB_OFS_LPER, 32'h00000040, 1'b0);
         rdchk(CTDB_OFS_HPER, 32'h00000000, 1'b0);
         wait_irq(1'b0, 200);
         `CHK("lower ignored", 1'b0, got)
      end
      wr(CTDB_OFS_CTRL, 8'h00);
      wr(CTDB_OFS_HMODE, 8'h0f);
      wr(CTDB_OFS_CTRL, 8'h06);
      wait_irq(1'b1, 600);
      `CHK("external input irq", 1'b0, got)
      wr(CTDB_OFS_CTRL, 8'h04);
      rdchk(CTDB_OFS_STAT, 32'h00000000, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
